/* hdl/dssc_consts.svh */
/*
  constants of the dual synth serial command controller: register
  indices, reset values, command characters, preset scale words.
  assumes one include per compile unit; guarded.
*/
`ifndef DSSC_CONSTS_SVH
`define DSSC_CONSTS_SVH

// ****************************************
// register indices
// ****************************************
`define DSSC_REG_HOLD 4'h0
`define DSSC_REG_DROP_ADDR 4'h1
`define DSSC_REG_TUNE_A 4'h2
`define DSSC_REG_TUNE_B 4'h3
`define DSSC_REG_STATUS 4'h4
`define DSSC_REG_ERRCNT 4'h5
`define DSSC_REG_SCALE_A 4'h6
`define DSSC_REG_SCALE_B 4'h7

// ****************************************
// reset values and limits
// ****************************************
`define DSSC_RST_WORD 32'h0000_0000
`define DSSC_RST_DROP_ADDR 8'h00
`define DSSC_PHASE_MAX 32'h0000_0010
`define DSSC_INFO_LEN 5'h04
`define DSSC_XINFO_LEN 5'h10
`define DSSC_X_CONT_MAX 8'h12

// ****************************************
// command characters
// ****************************************
`define DSSC_CH_OUT_A 8'h61
`define DSSC_CH_SET_OUT_A 8'h41
`define DSSC_CH_OUT_B 8'h62
`define DSSC_CH_SET_OUT_B 8'h42
`define DSSC_CH_CLEAR 8'h63
`define DSSC_CH_DOWN_A 8'h64
`define DSSC_CH_DOWN_B 8'h44
`define DSSC_CH_ERROR 8'h65
`define DSSC_CH_DEC_A 8'h66
`define DSSC_CH_DEC_B 8'h46
`define DSSC_CH_GLOBAL 8'h67
`define DSSC_CH_RESTORE 8'h47
`define DSSC_CH_DIRECT_A 8'h68
`define DSSC_CH_DIRECT_B 8'h48
`define DSSC_CH_INFO 8'h69
`define DSSC_CH_XINFO 8'h49
`define DSSC_CH_INC_A 8'h6A
`define DSSC_CH_INC_B 8'h4A
`define DSSC_CH_KILL 8'h6B
`define DSSC_CH_LISTEN 8'h6C
`define DSSC_CH_SET_ADDR 8'h4C
`define DSSC_CH_MASK 8'h6D
`define DSSC_CH_NORMAL 8'h6E
`define DSSC_CH_SILENT 8'h4E
`define DSSC_CH_SPARE_LO 8'h6F
`define DSSC_CH_SPARE_HI 8'h4F
`define DSSC_CH_PHASE_A 8'h70
`define DSSC_CH_PHASE_B 8'h50
`define DSSC_CH_SCALE_A 8'h73
`define DSSC_CH_SCALE_B 8'h53
`define DSSC_CH_UP_A 8'h75
`define DSSC_CH_UP_B 8'h55
`define DSSC_CH_PRESET 8'h78
`define DSSC_CH_PROMPT 8'h3E
`define DSSC_CH_ZERO 8'h30
`define DSSC_CH_NINE 8'h39

// ****************************************
// clock scale presets: nominal clock and loaded word
// ****************************************
`define DSSC_X_25 8'h19
`define DSSC_X_50 8'h32
`define DSSC_X_100 8'h64
`define DSSC_X_125 8'h7D
`define DSSC_X_180 8'hB4
`define DSSC_SCALE_25 32'h0000_0019
`define DSSC_SCALE_50 32'h0000_0032
`define DSSC_SCALE_100 32'h0000_0064
`define DSSC_SCALE_125 32'h0000_007D
`define DSSC_SCALE_180 32'h0000_00B4

`endif

/* hdl/dssc_ctrl.sv */
/*
  command interpreter driving two synth channels from serial characters.
  assumes an already framed byte stream on rx/tx with valid/ready, numeric
  entry delivered through the hold register, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "dssc_consts.svh"

// How it works
// - command a loads channel one synth from its tuning store
// - command b loads channel two synth from its tuning store
// - command A copies hold into tuning store one and drives synth one
// - command B copies hold into tuning store two and drives synth two
// - x presets put clock scale into hold; s and S take it into use
// - clear drives fault line high and zeroes error counter
// - forced error drives fault line low and counts one error
// - f and F subtract hold from tuning store, synth output unchanged
// - global saves listen state then makes this drop listen
// - restore puts back the listen state saved earlier
// - h drives synth one from temp copy of hold, stores untouched
// - H drives synth two from temp copy of hold, stores untouched
// - i sends tuning word; I sends larger register dump over serial
// - j and J add hold to the channel tuning store
// - kill ignores matching drop and saves ignore as restore state
// - listen enables matching drop and saves listen as restore state
// - L takes drop address from hold; host isolates other drops
// - mask saves listen state then puts drop in ignore
// - normal mode echoes characters and sends prompts
// - silent mode sends nothing, pulses fault line low per command
// - o drives spare line low, O drives it high
// - p and P load phase from hold, range zero to sixteen
// - hold writes, listen and kill act regardless of listen state
module dssc_ctrl #(
  parameter int ERR_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [31:0] syn_a_word_o,
  output logic syn_a_load_o,
  output logic [4:0] syn_a_phase_o,
  output logic syn_a_pdown_o,
  output logic [31:0] syn_b_word_o,
  output logic syn_b_load_o,
  output logic [4:0] syn_b_phase_o,
  output logic syn_b_pdown_o,
  output logic fault_indicator_line_n_o,
  output logic spare_output_line_o
);

  default clocking chk_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // ****************************************
  // state
  // ****************************************
  dssc_pkg::dssc_state_t state_reg, ret_reg;
  logic [31:0] hold_reg, tune_a_reg, tune_b_reg, temp_reg;
  logic [31:0] scale_a_reg, scale_b_reg;
  logic [7:0] drop_addr_reg, xval_reg, echo_reg;
  logic [1:0] xcnt_reg;
  logic [4:0] tx_idx_reg, tx_end_reg;
  logic [ERR_W-1:0] errcnt_reg;
  logic listen_reg, saved_reg, silent_reg, err_reg, prompt_reg;
  logic temp_a_reg, temp_b_reg;

  // ****************************************
  // character decode
  // ****************************************
  logic take, in_x, c_ok, always_ch, known, dig, x_hit, x_more, x_bad;
  logic do_a, do_A, do_b, do_B, do_c, do_e, do_f, do_F, do_g, do_G;
  logic do_h, do_H, do_i, do_I, do_j, do_J, do_k, do_l, do_L, do_m;
  logic do_p, do_P, do_x, phase_bad, err_evt, done, addr_hit, tx_go;
  logic [7:0] ch, x_v;
  logic [4:0] info_n;
  logic [31:0] preset;

  assign ch = rx_data_i;
  assign rx_ready_o = (state_reg != dssc_pkg::DSSC_TX);
  assign take = rx_valid_i && rx_ready_o;
  assign in_x = (state_reg == dssc_pkg::DSSC_XPFX);
  assign always_ch = (ch == `DSSC_CH_LISTEN) || (ch == `DSSC_CH_KILL) ||
                     (ch == `DSSC_CH_GLOBAL) || (ch == `DSSC_CH_RESTORE) ||
                     (ch == `DSSC_CH_MASK) || (ch == `DSSC_CH_SET_ADDR);
  assign c_ok = take && !in_x && (listen_reg || always_ch);
  assign do_a = c_ok && (ch == `DSSC_CH_OUT_A);
  assign do_A = c_ok && (ch == `DSSC_CH_SET_OUT_A);
  assign do_b = c_ok && (ch == `DSSC_CH_OUT_B);
  assign do_B = c_ok && (ch == `DSSC_CH_SET_OUT_B);
  assign do_c = c_ok && (ch == `DSSC_CH_CLEAR);
  assign do_e = c_ok && (ch == `DSSC_CH_ERROR);
  assign do_f = c_ok && (ch == `DSSC_CH_DEC_A);
  assign do_F = c_ok && (ch == `DSSC_CH_DEC_B);
  assign do_g = c_ok && (ch == `DSSC_CH_GLOBAL);
  assign do_G = c_ok && (ch == `DSSC_CH_RESTORE);
  assign do_h = c_ok && (ch == `DSSC_CH_DIRECT_A);
  assign do_H = c_ok && (ch == `DSSC_CH_DIRECT_B);
  assign do_i = c_ok && (ch == `DSSC_CH_INFO);
  assign do_I = c_ok && (ch == `DSSC_CH_XINFO);
  assign do_j = c_ok && (ch == `DSSC_CH_INC_A);
  assign do_J = c_ok && (ch == `DSSC_CH_INC_B);
  assign do_k = c_ok && (ch == `DSSC_CH_KILL);
  assign do_l = c_ok && (ch == `DSSC_CH_LISTEN);
  assign do_L = c_ok && (ch == `DSSC_CH_SET_ADDR);
  assign do_m = c_ok && (ch == `DSSC_CH_MASK);
  assign do_p = c_ok && (ch == `DSSC_CH_PHASE_A);
  assign do_P = c_ok && (ch == `DSSC_CH_PHASE_B);
  assign do_x = c_ok && (ch == `DSSC_CH_PRESET);

  always_comb begin
    case (ch)
      `DSSC_CH_OUT_A, `DSSC_CH_SET_OUT_A, `DSSC_CH_OUT_B,
      `DSSC_CH_SET_OUT_B, `DSSC_CH_CLEAR, `DSSC_CH_DOWN_A,
      `DSSC_CH_DOWN_B, `DSSC_CH_ERROR, `DSSC_CH_DEC_A, `DSSC_CH_DEC_B,
      `DSSC_CH_GLOBAL, `DSSC_CH_RESTORE, `DSSC_CH_DIRECT_A,
      `DSSC_CH_DIRECT_B, `DSSC_CH_INFO, `DSSC_CH_XINFO, `DSSC_CH_INC_A,
      `DSSC_CH_INC_B, `DSSC_CH_KILL, `DSSC_CH_LISTEN, `DSSC_CH_SET_ADDR,
      `DSSC_CH_MASK, `DSSC_CH_NORMAL, `DSSC_CH_SILENT, `DSSC_CH_SPARE_LO,
      `DSSC_CH_SPARE_HI, `DSSC_CH_PHASE_A, `DSSC_CH_PHASE_B,
      `DSSC_CH_SCALE_A, `DSSC_CH_SCALE_B, `DSSC_CH_UP_A, `DSSC_CH_UP_B,
      `DSSC_CH_PRESET: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // ****************************************
  // clock scale preset parser
  // ****************************************
  assign dig = (ch >= `DSSC_CH_ZERO) && (ch <= `DSSC_CH_NINE);
  assign x_v = 8'(xval_reg * 8'd10 + (ch - `DSSC_CH_ZERO));

  always_comb begin
    case (x_v)
      `DSSC_X_25: preset = `DSSC_SCALE_25;
      `DSSC_X_50: preset = `DSSC_SCALE_50;
      `DSSC_X_100: preset = `DSSC_SCALE_100;
      `DSSC_X_125: preset = `DSSC_SCALE_125;
      `DSSC_X_180: preset = `DSSC_SCALE_180;
      default: preset = `DSSC_RST_WORD;
    endcase
  end

  assign x_hit = in_x && take && dig && (preset != `DSSC_RST_WORD);
  assign x_more = in_x && take && dig && !x_hit &&
                  (x_v <= `DSSC_X_CONT_MAX) && (xcnt_reg != 2'd2);
  assign x_bad = in_x && take && !x_hit && !x_more;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      xval_reg <= 8'h00;
      xcnt_reg <= 2'd0;
    end else if (do_x) begin
      xval_reg <= 8'h00;
      xcnt_reg <= 2'd0;
    end else if (x_more) begin
      xval_reg <= x_v;
      xcnt_reg <= xcnt_reg + 2'd1;
    end
  end

  // ****************************************
  // errors and completion
  // ****************************************
  assign phase_bad = (do_p || do_P) && (hold_reg > `DSSC_PHASE_MAX);
  assign err_evt = do_e || (c_ok && !known) || x_bad || phase_bad;
  assign done = (c_ok && !do_x) || x_hit || x_bad;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      err_reg <= 1'b0;
      errcnt_reg <= '0;
    end else if (err_evt) begin
      err_reg <= 1'b1;
      errcnt_reg <= errcnt_reg + 1'b1;
    end else if (do_c) begin
      err_reg <= 1'b0;
      errcnt_reg <= '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      fault_indicator_line_n_o <= 1'b1;
    else
      fault_indicator_line_n_o <= !((err_reg && !do_c) || err_evt ||
                                   (silent_reg && done));
  end

  // ****************************************
  // hold register and software writes
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      hold_reg <= `DSSC_RST_WORD;
    else if (reg_wr_i && reg_addr_i == `DSSC_REG_HOLD)
      hold_reg <= reg_wdata_i;
    else if (x_hit)
      hold_reg <= preset;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      scale_a_reg <= `DSSC_RST_WORD;
      scale_b_reg <= `DSSC_RST_WORD;
    end else begin
      if (c_ok && ch == `DSSC_CH_SCALE_A)
        scale_a_reg <= hold_reg;
      if (c_ok && ch == `DSSC_CH_SCALE_B)
        scale_b_reg <= hold_reg;
    end
  end

  // ****************************************
  // tuning stores
  // ****************************************
  // store A, increment, decrement
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      tune_a_reg <= `DSSC_RST_WORD;
    else if (do_A)
      tune_a_reg <= hold_reg;
    else if (do_j)
      tune_a_reg <= tune_a_reg + hold_reg;
    else if (do_f)
      tune_a_reg <= tune_a_reg - hold_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      tune_b_reg <= `DSSC_RST_WORD;
    else if (do_B)
      tune_b_reg <= hold_reg;
    else if (do_J)
      tune_b_reg <= tune_b_reg + hold_reg;
    else if (do_F)
      tune_b_reg <= tune_b_reg - hold_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      temp_reg <= `DSSC_RST_WORD;
      temp_a_reg <= 1'b0;
      temp_b_reg <= 1'b0;
    end else begin
      if (do_h || do_H)
        temp_reg <= hold_reg;
      temp_a_reg <= do_h;
      temp_b_reg <= do_H;
    end
  end

  // ****************************************
  // synth outputs
  // ****************************************
  // channel one load
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      syn_a_word_o <= `DSSC_RST_WORD;
      syn_a_load_o <= 1'b0;
    end else begin
      syn_a_load_o <= do_a || do_A || temp_a_reg;
      if (do_a)
        syn_a_word_o <= tune_a_reg;
      else if (do_A)
        syn_a_word_o <= hold_reg;
      else if (temp_a_reg)
        syn_a_word_o <= temp_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      syn_b_word_o <= `DSSC_RST_WORD;
      syn_b_load_o <= 1'b0;
    end else begin
      syn_b_load_o <= do_b || do_B || temp_b_reg;
      if (do_b)
        syn_b_word_o <= tune_b_reg;
      else if (do_B)
        syn_b_word_o <= hold_reg;
      else if (temp_b_reg)
        syn_b_word_o <= temp_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      syn_a_phase_o <= 5'h00;
      syn_b_phase_o <= 5'h00;
      syn_a_pdown_o <= 1'b0;
      syn_b_pdown_o <= 1'b0;
    end else begin
      if (do_p && !phase_bad)
        syn_a_phase_o <= hold_reg[4:0];
      if (do_P && !phase_bad)
        syn_b_phase_o <= hold_reg[4:0];
      if (c_ok && ch == `DSSC_CH_DOWN_A)
        syn_a_pdown_o <= 1'b1;
      else if (c_ok && ch == `DSSC_CH_UP_A)
        syn_a_pdown_o <= 1'b0;
      if (c_ok && ch == `DSSC_CH_DOWN_B)
        syn_b_pdown_o <= 1'b1;
      else if (c_ok && ch == `DSSC_CH_UP_B)
        syn_b_pdown_o <= 1'b0;
    end
  end

  // ****************************************
  // drop addressing and modes
  // ****************************************
  assign addr_hit = (hold_reg[7:0] == drop_addr_reg);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      listen_reg <= 1'b1;
      saved_reg <= 1'b1;
    end else if (do_g || do_m) begin
      saved_reg <= listen_reg;
      listen_reg <= do_g;
    end else if (do_G) begin
      listen_reg <= saved_reg;
    end else if ((do_l || do_k) && addr_hit) begin
      listen_reg <= do_l;
      saved_reg <= do_l;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      drop_addr_reg <= `DSSC_RST_DROP_ADDR;
      silent_reg <= 1'b0;
      spare_output_line_o <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `DSSC_REG_DROP_ADDR)
        drop_addr_reg <= reg_wdata_i[7:0];
      else if (do_L)
        drop_addr_reg <= hold_reg[7:0];
      if (c_ok && ch == `DSSC_CH_NORMAL)
        silent_reg <= 1'b0;
      else if (c_ok && ch == `DSSC_CH_SILENT)
        silent_reg <= 1'b1;
      if (c_ok && ch == `DSSC_CH_SPARE_LO)
        spare_output_line_o <= 1'b0;
      else if (c_ok && ch == `DSSC_CH_SPARE_HI)
        spare_output_line_o <= 1'b1;
    end
  end

  // ****************************************
  // serial responses
  // ****************************************
  // echo only when speaking
  assign tx_go = ((c_ok && listen_reg) || (in_x && take)) && !silent_reg;
  assign info_n = do_i ? `DSSC_INFO_LEN : (do_I ? `DSSC_XINFO_LEN : 5'h00);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= dssc_pkg::DSSC_IDLE;
      ret_reg <= dssc_pkg::DSSC_IDLE;
      tx_idx_reg <= 5'h00;
      tx_end_reg <= 5'h00;
      echo_reg <= 8'h00;
      prompt_reg <= 1'b0;
    end else begin
      case (state_reg)
        dssc_pkg::DSSC_IDLE, dssc_pkg::DSSC_XPFX: begin
          if (take) begin
            ret_reg <= (do_x || x_more) ? dssc_pkg::DSSC_XPFX
                                        : dssc_pkg::DSSC_IDLE;
            if (tx_go) begin
              state_reg <= dssc_pkg::DSSC_TX;
              tx_idx_reg <= 5'h00;
              tx_end_reg <= info_n + {4'h0, done};
              echo_reg <= ch;
              prompt_reg <= done;
            end else if (do_x || x_more) begin
              state_reg <= dssc_pkg::DSSC_XPFX;
            end else begin
              state_reg <= dssc_pkg::DSSC_IDLE;
            end
          end
        end
        dssc_pkg::DSSC_TX: begin
          if (tx_ready_i) begin
            tx_idx_reg <= tx_idx_reg + 5'h01;
            if (tx_idx_reg == tx_end_reg)
              state_reg <= ret_reg;
          end
        end
        default: state_reg <= dssc_pkg::DSSC_IDLE;
      endcase
    end
  end

  logic [127:0] info_vec, info_sh;
  assign info_vec = {tune_a_reg, tune_b_reg, hold_reg,
                     {(32-ERR_W){1'b0}}, errcnt_reg};
  assign info_sh = info_vec << {tx_idx_reg - 5'h01, 3'b000};
  assign tx_valid_o = (state_reg == dssc_pkg::DSSC_TX);

  always_comb begin
    if (tx_idx_reg == 5'h00)
      tx_data_o = echo_reg;
    else if (prompt_reg && tx_idx_reg == tx_end_reg)
      tx_data_o = `DSSC_CH_PROMPT;
    else
      tx_data_o = info_sh[127:120];
  end

  // ****************************************
  // register port
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i) begin
      case (reg_addr_i)
        `DSSC_REG_HOLD: reg_rdata_o <= hold_reg;
        `DSSC_REG_DROP_ADDR: reg_rdata_o <= {24'h00_0000, drop_addr_reg};
        `DSSC_REG_TUNE_A: reg_rdata_o <= tune_a_reg;
        `DSSC_REG_TUNE_B: reg_rdata_o <= tune_b_reg;
        `DSSC_REG_STATUS: reg_rdata_o <= {26'h000_0000, err_reg,
            silent_reg, saved_reg, listen_reg, syn_b_pdown_o,
            syn_a_pdown_o};
        `DSSC_REG_ERRCNT: reg_rdata_o <= {{(32-ERR_W){1'b0}}, errcnt_reg};
        `DSSC_REG_SCALE_A: reg_rdata_o <= scale_a_reg;
        `DSSC_REG_SCALE_B: reg_rdata_o <= scale_b_reg;
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end else
      reg_rdata_o <= 32'h0000_0000;
  end

  // ****************************************
  // checks
  // ****************************************
  sequence seq_enter;
    do_g || do_m;
  endsequence

  out_a_load_a: assert property (do_a |=> syn_a_load_o &&
    syn_a_word_o == $past(tune_a_reg))
    else $error("channel one not loaded from store");
  out_b_load_a: assert property (do_b |=> syn_b_load_o &&
    syn_b_word_o == $past(tune_b_reg))
    else $error("channel two not loaded from store");
  set_out_a_a: assert property (do_A |=>
    tune_a_reg == $past(hold_reg) && syn_a_word_o == tune_a_reg)
    else $error("set and output one mismatch");
  clear_err_a: assert property (do_c && !silent_reg |=>
    fault_indicator_line_n_o && errcnt_reg == '0)
    else $error("clear did not end error");
  force_err_a: assert property (do_e |=> !fault_indicator_line_n_o &&
    errcnt_reg == $past(errcnt_reg) + 1'b1)
    else $error("forced error not counted");
  dec_a_hold_a: assert property (do_f |=>
    tune_a_reg == $past(tune_a_reg) - $past(hold_reg) &&
    $stable(syn_a_word_o) && !syn_a_load_o)
    else $error("decrement touched the output");
  direct_a_a: assert property (do_h |=> $stable(tune_a_reg) ##1
    syn_a_load_o && syn_a_word_o == $past(hold_reg, 2))
    else $error("direct output one wrong");
  global_rest_a: assert property (do_G |=>
    listen_reg == $past(saved_reg))
    else $error("restore lost the saved state");
  global_on_a: assert property (do_g |=>
    listen_reg && saved_reg == $past(listen_reg))
    else $error("global did not enable drop");
  mask_save_a: assert property (seq_enter |=>
    saved_reg == $past(listen_reg) && listen_reg == $past(do_g))
    else $error("mask or global did not save state");
  silent_tx_a: assert property (
    silent_reg && done && !err_evt && !err_reg |=>
    !fault_indicator_line_n_o ##1 (fault_indicator_line_n_o || err_reg))
    else $error("silent completion pulse wrong");
  spare_hi_a: assert property (
    c_ok && ch == `DSSC_CH_SPARE_HI |=> spare_output_line_o)
    else $error("spare line not set");

endmodule

/* hdl/dssc_pkg.sv */
/*
  types of the dual synth serial command controller.
  assumes nothing of its surroundings.
*/
package dssc_pkg;
  typedef enum logic [1:0] {
    DSSC_IDLE = 2'b00,
    DSSC_XPFX = 2'b01,
    DSSC_TX = 2'b11
  } dssc_state_t;
endpackage

/* verification/dssc_ctrl_tb.sv */
/*
  bench of dssc_ctrl: register tasks and command strings via host model.
  assumes dssc_ctrl and dssc_host_model compiled before it.
*/
`timescale 1ns/1ps
module dssc_ctrl_tb;
  logic clk = 0, rst = 1, wr = 0, rs = 0, snd = 0, slow = 0;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdat, wa, wb, la, lb;
  logic [7:0] ch = 8'h00, rxd, txd;
  logic [47:0] tsh = 48'h0000_0000_0000;
  logic rxv, rxr, txv, txr, lda, ldb, pa, pb, flt, spr;
  logic [4:0] pha, phb;
  int mismatches = 0, tests_run = 0, ntx = 0, nf = 0, n0, n1;
  initial forever #10 clk = ~clk;
  dssc_host_model host (.sys_clk_i(clk), .srst_i(rst), .char_i(ch),
    .send_i(snd), .slow_i(slow), .rx_ready_i(rxr), .rx_data_o(rxd),
    .rx_valid_o(rxv), .tx_ready_o(txr));
  dssc_ctrl dut (.sys_clk_i(clk), .srst_i(rst), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rs), .reg_rdata_o(rdat),
    .rx_data_i(rxd), .rx_valid_i(rxv), .rx_ready_o(rxr), .tx_data_o(txd),
    .tx_valid_o(txv), .tx_ready_i(txr), .syn_a_word_o(wa),
    .syn_a_load_o(lda), .syn_a_phase_o(pha), .syn_a_pdown_o(pa),
    .syn_b_word_o(wb), .syn_b_load_o(ldb), .syn_b_phase_o(phb),
    .syn_b_pdown_o(pb), .fault_indicator_line_n_o(flt),
    .spare_output_line_o(spr));
  // ****************************************
  // monitors and tasks
  // ****************************************
  always @(posedge clk) begin
    if (lda) la <= wa;
    if (ldb) lb <= wb;
    if (txv && txr) begin
      ntx <= ntx + 1;
      tsh <= {tsh[39:0], txd};
    end
    if (!flt) nf <= nf + 1;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rs <= 1'b1;
    ad <= a;
    @(posedge clk);
    rs <= 1'b0;
    #1;
    chk(n, rdat, e);
  endtask
  task automatic cs(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      snd <= 1'b1;
      ch <= s[i];
      @(posedge clk);
      snd <= 1'b0;
      #1;
      for (int k = 0; k < 100 && (rxv || !rxr); k++) @(posedge clk) #1;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  // ****************************************
  // command sequences
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc("status", 4'h4, 32'h0000_000C);
    wreg(4'h0, 32'h0000_0064);
    cs("A");
    rc("tune a", 4'h2, 32'h0000_0064);
    chk("out a", la, 32'h0000_0064);
    wreg(4'h0, 32'h0000_00C8);
    cs("B");
    chk("out b", lb, 32'h0000_00C8);
    wreg(4'h0, 32'h0000_0005);
    cs("jff");
    rc("tune a adj", 4'h2, 32'h0000_005F);
    chk("no load", la, 32'h0000_0064);
    cs("a");
    chk("out a", la, 32'h0000_005F);
    wreg(4'h0, 32'h0000_0003);
    cs("JFFb");
    chk("out b", lb, 32'h0000_00C5);
    wreg(4'h0, 32'h0000_0007);
    cs("hH");
    chk("temp a", la, 32'h0000_0007);
    chk("temp b", lb, 32'h0000_0007);
    rc("tune a", 4'h2, 32'h0000_005F);
    rc("tune b", 4'h3, 32'h0000_00C5);
    rc("hold", 4'h0, 32'h0000_0007);
    cs("e");
    chk("fault", 32'(flt), 32'h0000_0000);
    rc("errors", 4'h5, 32'h0000_0001);
    cs("c");
    chk("fault", 32'(flt), 32'h0000_0001);
    rc("errors", 4'h5, 32'h0000_0000);
    cs("O");
    chk("spare", 32'(spr), 32'h0000_0001);
    cs("o");
    chk("spare", 32'(spr), 32'h0000_0000);
    cs("d");
    chk("pdown", 32'({pb, pa}), 32'h0000_0001);
    cs("Du");
    chk("pdown", 32'({pb, pa}), 32'h0000_0002);
    cs("U");
    wreg(4'h0, 32'h0000_0010);
    cs("p");
    wreg(4'h0, 32'h0000_0011);
    cs("p");
    chk("phase a", 32'(pha), 32'h0000_0010);
    rc("errors", 4'h5, 32'h0000_0001);
    wreg(4'h0, 32'h0000_0003);
    cs("cP");
    chk("phase b", 32'(phb), 32'h0000_0003);
    cs("x25");
    rc("preset", 4'h0, 32'h0000_0019);
    cs("x50");
    rc("preset", 4'h0, 32'h0000_0032);
    cs("x125");
    rc("preset", 4'h0, 32'h0000_007D);
    cs("x100s");
    rc("scale a", 4'h6, 32'h0000_0064);
    cs("x180S");
    rc("scale b", 4'h7, 32'h0000_00B4);
    slow <= 1'b1;
    n0 = ntx;
    cs("i");
    chk("info", 32'(ntx - n0), 32'h0000_0006);
    chk("info word", tsh[39:8], 32'h0000_005F);
    chk("info frame", 32'({tsh[47:40], tsh[7:0]}), 32'h0000_693E);
    n0 = ntx;
    cs("I");
    chk("xinfo", 32'(ntx - n0), 32'h0000_0012);
    chk("xinfo tail", tsh[47:16], 32'hB400_0000);
    slow <= 1'b0;
    cs("N");
    n0 = ntx;
    n1 = nf;
    cs("O");
    chk("silent", 32'(ntx - n0), 32'h0000_0000);
    chk("pulse", 32'(nf - n1), 32'h0000_0001);
    cs("n");
    wreg(4'h1, 32'h0000_0001);
    wreg(4'h0, 32'h0000_0002);
    cs("k");
    rc("other", 4'h4, 32'h0000_000C);
    wreg(4'h0, 32'h0000_0001);
    cs("ka");
    rc("killed", 4'h4, 32'h0000_0000);
    chk("dropped", la, 32'h0000_0007);
    cs("g");
    rc("global", 4'h4, 32'h0000_0004);
    cs("G");
    rc("restore", 4'h4, 32'h0000_0000);
    cs("l");
    rc("listen", 4'h4, 32'h0000_000C);
    cs("m");
    rc("mask", 4'h4, 32'h0000_0008);
    cs("G");
    rc("unmask", 4'h4, 32'h0000_000C);
    wreg(4'h0, 32'h0000_0003);
    cs("L");
    rc("address", 4'h1, 32'h0000_0003);
    rc("unmapped", 4'hF, 32'h0000_0000);
    stop_test();
  end
endmodule

/* verification/dssc_host_model.sv */
/*
  host model: sends one command character on request and holds it until
  taken; accepts responses, promptly or every other cycle.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module dssc_host_model (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] char_i,
  input wire logic send_i,
  input wire logic slow_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic tx_ready_o
);
  // ****************************************
  // character sender
  // ****************************************
  // sole host
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
    end else if (send_i) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= char_i;
    end else if (rx_valid_o && rx_ready_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= ~rx_data_o;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    tx_ready_o <= srst_i ? 1'b0 : (slow_i ? ~tx_ready_o : 1'b1);
  end
endmodule
